/* File: logic/ssc_pkg.sv */
package ssc_pkg;

	// Bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// Register indices; byte address is four times the index
	localparam logic [7:0] SUPPLY_MONITOR_CTRL_IDX   = 8'he3;
	localparam logic [7:0] BANDGAP_TRIM_SECOND_IDX   = 8'he4;
	localparam logic [7:0] TRANSIENT_DETECT_CTRL_IDX = 8'he5;

	localparam logic [11:0] SUPPLY_MONITOR_CTRL_ADDR   = {2'h0, SUPPLY_MONITOR_CTRL_IDX, 2'h0};
	localparam logic [11:0] BANDGAP_TRIM_SECOND_ADDR   = {2'h0, BANDGAP_TRIM_SECOND_IDX, 2'h0};
	localparam logic [11:0] TRANSIENT_DETECT_CTRL_ADDR = {2'h0, TRANSIENT_DETECT_CTRL_IDX, 2'h0};

	// Supply monitor control fields
	localparam int unsigned POR_OFF_BIT    = 5;
	localparam int unsigned LOWV_OFF_BIT   = 4;
	localparam int unsigned LOWV_SEL_LSB   = 0;
	localparam int unsigned LOWV_SEL_W     = 4;

	// Bandgap trim field
	localparam int unsigned TRIM_LSB       = 0;
	localparam int unsigned TRIM_W         = 5;

	// Transient detect control fields
	localparam int unsigned DET2_EN_BIT    = 7;
	localparam int unsigned DET1_EN_BIT    = 6;
	localparam int unsigned DET1_SENS_LSB  = 4;
	localparam int unsigned DET1_SENS_W    = 2;
	localparam int unsigned FORCE_SLOW_BIT = 3;
	localparam int unsigned WAIT_PIN_BIT   = 1;

	// Values after reset
	localparam logic           POR_OFF_RST    = 1'h0;
	localparam logic           LOWV_OFF_RST   = 1'h0;
	localparam logic [3:0]     LOWV_SEL_RST   = 4'h0;
	localparam logic [4:0]     TRIM_RST       = 5'h00;
	localparam logic           DET2_EN_RST    = 1'h0;
	localparam logic           DET1_EN_RST    = 1'h0;
	localparam logic [1:0]     DET1_SENS_RST  = 2'h0;
	localparam logic           FORCE_SLOW_RST = 1'h0;
	localparam logic           WAIT_PIN_RST   = 1'h0;

	// Responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register select codes
	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_SUPPLY,
		SEL_TRIM,
		SEL_TRANSIENT
	} ssc_sel_e;

endpackage : ssc_pkg

/* File: logic/ssc_sync2.sv */
`timescale 1ns/1ps
module ssc_sync2 (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Level in and out
	input  wire logic async_in,
	output logic      sync_out
);

	logic stage1_r;
	logic stage1_nxt;
	logic stage2_r;
	logic stage2_nxt;

	always_comb begin
		stage1_nxt = async_in;
		stage2_nxt = stage1_r;
	end

	// First stage feeds only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1_r <= 1'b0;
			stage2_r <= 1'b0;
		end else begin
			stage1_r <= stage1_nxt;
			stage2_r <= stage2_nxt;
		end
	end

	assign sync_out = stage2_r;

endmodule : ssc_sync2

/* File: logic/ssc_regs.sv */
// Function
// RULE_01 - Supply control bit 5 turns the power-on reset circuit off when 1, on when 0, reset 0.
// RULE_02 - Supply control bit 4 turns the low-voltage reset circuit off when 1, on when 0, reset 0.
// RULE_03 - Supply control bits 3:0 pick the low-voltage reset threshold, 0 lowest to 15 highest.
// RULE_04 - Bandgap trim register bits 4:0 hold a read/write trim value for the reference.
// RULE_05 - Transient control bit 7 enables the second transient detector, reset 0.
// RULE_06 - Transient control bit 6 enables the first transient detector, reset 0.
// RULE_07 - Transient control bits 5:4 set the first detector's sensitivity, reset 00.
// RULE_08 - Transient control bit 3 forces the system clock to the slow clock during a transient.
// RULE_09 - Transient control bit 1 puts the transient-wait indicator on the shared pin.
// RULE_10 - When the transient ends the system clock goes back to the software-chosen source.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module ssc_regs (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Analog supervisor controls
	output logic             poweron_reset_off,
	output logic             low_volt_reset_off,
	output logic [3:0]       low_volt_threshold_sel,
	output logic [4:0]       reference_trim_second,
	output logic             transient_det2_en,
	output logic             transient_det1_en,
	output logic [1:0]       transient_det1_sensitivity,
	// Transient detection and clock selection
	input  wire logic        transient_detected_async,
	input  wire logic        sw_slow_clock_sel,
	output logic             transient_wait_indicator,
	output logic             system_clock_use_slow,
	// Shared port pin
	input  wire logic        gpio_pin_out,
	input  wire logic        gpio_pin_oe,
	output logic             shared_pin_out,
	output logic             shared_pin_oe
);

	function automatic ssc_pkg::ssc_sel_e decode(input logic [11:0] addr);
		ssc_pkg::ssc_sel_e sel;
		sel = ssc_pkg::SEL_NONE;
		case (addr)
			ssc_pkg::SUPPLY_MONITOR_CTRL_ADDR:   sel = ssc_pkg::SEL_SUPPLY;
			ssc_pkg::BANDGAP_TRIM_SECOND_ADDR:   sel = ssc_pkg::SEL_TRIM;
			ssc_pkg::TRANSIENT_DETECT_CTRL_ADDR: sel = ssc_pkg::SEL_TRANSIENT;
			default:                             sel = ssc_pkg::SEL_NONE;
		endcase
		return sel;
	endfunction : decode

	// Register storage
	logic       por_off_r,    por_off_nxt;
	logic       lowv_off_r,   lowv_off_nxt;
	logic [3:0] lowv_sel_r,   lowv_sel_nxt;
	logic [4:0] trim_r,       trim_nxt;
	logic       det2_en_r,    det2_en_nxt;
	logic       det1_en_r,    det1_en_nxt;
	logic [1:0] det1_sens_r,  det1_sens_nxt;
	logic       force_slow_r, force_slow_nxt;
	logic       wait_pin_r,   wait_pin_nxt;

	// Write channel state
	logic        aw_held_r, aw_held_nxt;
	logic [11:0] waddr_r,   waddr_nxt;
	logic        w_held_r,  w_held_nxt;
	logic [7:0]  wdata_r,   wdata_nxt;
	logic        wstrb_r,   wstrb_nxt;
	logic        awready_r, awready_nxt;
	logic        wready_r,  wready_nxt;
	logic        bvalid_r,  bvalid_nxt;
	logic [1:0]  bresp_r,   bresp_nxt;

	// Read channel state
	logic        arready_r, arready_nxt;
	logic        rvalid_r,  rvalid_nxt;
	logic [31:0] rdata_r,   rdata_nxt;
	logic [1:0]  rresp_r,   rresp_nxt;

	// Transient path
	logic det_sync;
	logic wait_r,     wait_nxt;
	logic use_slow_r, use_slow_nxt;
	logic pin_out_r,  pin_out_nxt;
	logic pin_oe_r,   pin_oe_nxt;

	logic [7:0]         supply_view;
	logic [7:0]         trim_view;
	logic [7:0]         transient_view;
	ssc_pkg::ssc_sel_e  wsel;
	ssc_pkg::ssc_sel_e  rsel;
	logic               do_write;

	ssc_sync2 u_det_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (transient_detected_async),
		.sync_out (det_sync)
	);

	// Reserved bits read as zero
	always_comb begin
		supply_view    = {2'h0, por_off_r, lowv_off_r, lowv_sel_r};
		trim_view      = {3'h0, trim_r};
		transient_view = {det2_en_r, det1_en_r, det1_sens_r, force_slow_r, 1'b0, wait_pin_r,
			1'b0};
	end

	// Write path: address and data are taken in either order, response after both
	always_comb begin
		aw_held_nxt    = aw_held_r;
		waddr_nxt      = waddr_r;
		w_held_nxt     = w_held_r;
		wdata_nxt      = wdata_r;
		wstrb_nxt      = wstrb_r;
		bvalid_nxt     = bvalid_r;
		bresp_nxt      = bresp_r;
		por_off_nxt    = por_off_r;
		lowv_off_nxt   = lowv_off_r;
		lowv_sel_nxt   = lowv_sel_r;
		trim_nxt       = trim_r;
		det2_en_nxt    = det2_en_r;
		det1_en_nxt    = det1_en_r;
		det1_sens_nxt  = det1_sens_r;
		force_slow_nxt = force_slow_r;
		wait_pin_nxt   = wait_pin_r;
		if (s_axi_awvalid && awready_r) begin
			aw_held_nxt = 1'b1;
			waddr_nxt   = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r) begin
			w_held_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata[7:0];
			wstrb_nxt  = s_axi_wstrb[0];
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		wsel     = decode(waddr_nxt);
		do_write = aw_held_nxt && w_held_nxt && !bvalid_r;
		if (do_write) begin
			aw_held_nxt = 1'b0;
			w_held_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = (wsel == ssc_pkg::SEL_NONE) ? ssc_pkg::RESP_SLVERR : ssc_pkg::RESP_OKAY;
			if (wstrb_nxt) begin
				case (wsel)
					ssc_pkg::SEL_SUPPLY: begin
						por_off_nxt = wdata_nxt[ssc_pkg::POR_OFF_BIT]; // RULE_01
						lowv_off_nxt = wdata_nxt[ssc_pkg::LOWV_OFF_BIT]; // RULE_02
						lowv_sel_nxt = wdata_nxt[ssc_pkg::LOWV_SEL_LSB +: ssc_pkg::LOWV_SEL_W]; // RULE_03
					end
					ssc_pkg::SEL_TRIM: begin
						trim_nxt = wdata_nxt[ssc_pkg::TRIM_LSB +: ssc_pkg::TRIM_W]; // RULE_04
					end
					ssc_pkg::SEL_TRANSIENT: begin
						det2_en_nxt    = wdata_nxt[ssc_pkg::DET2_EN_BIT]; // RULE_05
						det1_en_nxt    = wdata_nxt[ssc_pkg::DET1_EN_BIT]; // RULE_06
						det1_sens_nxt  = wdata_nxt[ssc_pkg::DET1_SENS_LSB +: ssc_pkg::DET1_SENS_W]; // RULE_07
						force_slow_nxt = wdata_nxt[ssc_pkg::FORCE_SLOW_BIT]; // RULE_08
						wait_pin_nxt   = wdata_nxt[ssc_pkg::WAIT_PIN_BIT]; // RULE_09
					end
					default: begin
					end
				endcase
			end
		end
		// One write at a time: both channels stall until the response is taken
		awready_nxt = !aw_held_nxt && !bvalid_nxt;
		wready_nxt  = !w_held_nxt && !bvalid_nxt;
	end

	// Read path: one outstanding read, data registered
	always_comb begin
		arready_nxt = arready_r;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		rsel        = decode(s_axi_araddr);
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = ssc_pkg::RESP_OKAY;
			case (rsel)
				ssc_pkg::SEL_SUPPLY:    rdata_nxt = {24'h000000, supply_view};
				ssc_pkg::SEL_TRIM:      rdata_nxt = {24'h000000, trim_view};
				ssc_pkg::SEL_TRANSIENT: rdata_nxt = {24'h000000, transient_view};
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = ssc_pkg::RESP_SLVERR;
				end
			endcase
		end
		arready_nxt = !rvalid_nxt;
	end

	// Transient handling; the detectors only report while at least one is enabled
	always_comb begin
		wait_nxt     = det_sync && (det1_en_r || det2_en_r);
		// Forced slow clock is held only while a transient lasts, then the software choice returns
		use_slow_nxt = sw_slow_clock_sel || (force_slow_r && wait_r); // RULE_08 RULE_10
		if (wait_pin_r) begin
			pin_out_nxt = wait_r; // RULE_09
			pin_oe_nxt  = 1'b1;
		end else begin
			pin_out_nxt = gpio_pin_out;
			pin_oe_nxt  = gpio_pin_oe;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_off_r    <= ssc_pkg::POR_OFF_RST; // RULE_01
			lowv_off_r   <= ssc_pkg::LOWV_OFF_RST; // RULE_02
			lowv_sel_r   <= ssc_pkg::LOWV_SEL_RST; // RULE_03
			trim_r       <= ssc_pkg::TRIM_RST;
			det2_en_r    <= ssc_pkg::DET2_EN_RST; // RULE_05
			det1_en_r    <= ssc_pkg::DET1_EN_RST; // RULE_06
			det1_sens_r  <= ssc_pkg::DET1_SENS_RST; // RULE_07
			force_slow_r <= ssc_pkg::FORCE_SLOW_RST;
			wait_pin_r   <= ssc_pkg::WAIT_PIN_RST;
			aw_held_r    <= 1'b0;
			waddr_r      <= 12'h000;
			w_held_r     <= 1'b0;
			wdata_r      <= 8'h00;
			wstrb_r      <= 1'b0;
			awready_r    <= 1'b0;
			wready_r     <= 1'b0;
			bvalid_r     <= 1'b0;
			bresp_r      <= ssc_pkg::RESP_OKAY;
			arready_r    <= 1'b0;
			rvalid_r     <= 1'b0;
			rdata_r      <= 32'h00000000;
			rresp_r      <= ssc_pkg::RESP_OKAY;
			wait_r       <= 1'b0;
			use_slow_r   <= 1'b0;
			pin_out_r    <= 1'b0;
			pin_oe_r     <= 1'b0;
		end else begin
			por_off_r    <= por_off_nxt;
			lowv_off_r   <= lowv_off_nxt;
			lowv_sel_r   <= lowv_sel_nxt;
			trim_r       <= trim_nxt;
			det2_en_r    <= det2_en_nxt;
			det1_en_r    <= det1_en_nxt;
			det1_sens_r  <= det1_sens_nxt;
			force_slow_r <= force_slow_nxt;
			wait_pin_r   <= wait_pin_nxt;
			aw_held_r    <= aw_held_nxt;
			waddr_r      <= waddr_nxt;
			w_held_r     <= w_held_nxt;
			wdata_r      <= wdata_nxt;
			wstrb_r      <= wstrb_nxt;
			awready_r    <= awready_nxt;
			wready_r     <= wready_nxt;
			bvalid_r     <= bvalid_nxt;
			bresp_r      <= bresp_nxt;
			arready_r    <= arready_nxt;
			rvalid_r     <= rvalid_nxt;
			rdata_r      <= rdata_nxt;
			rresp_r      <= rresp_nxt;
			wait_r       <= wait_nxt;
			use_slow_r   <= use_slow_nxt;
			pin_out_r    <= pin_out_nxt;
			pin_oe_r     <= pin_oe_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign s_axi_awready              = awready_r;
	assign s_axi_wready               = wready_r;
	assign s_axi_bvalid               = bvalid_r;
	assign s_axi_bresp                = bresp_r;
	assign s_axi_arready              = arready_r;
	assign s_axi_rvalid               = rvalid_r;
	assign s_axi_rdata                = rdata_r;
	assign s_axi_rresp                = rresp_r;
	assign poweron_reset_off          = por_off_r;
	assign low_volt_reset_off         = lowv_off_r;
	assign low_volt_threshold_sel     = lowv_sel_r;
	assign reference_trim_second      = trim_r;
	assign transient_det2_en          = det2_en_r;
	assign transient_det1_en          = det1_en_r;
	assign transient_det1_sensitivity = det1_sens_r;
	assign transient_wait_indicator   = wait_r;
	assign system_clock_use_slow      = use_slow_r;
	assign shared_pin_out             = pin_out_r;
	assign shared_pin_oe              = pin_oe_r;

endmodule : ssc_regs

/* File: tb/ssc_regs_properties.sv */
`timescale 1ns/1ps
module ssc_regs_chk (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Write channels
	input wire logic [11:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// Read channels
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Controls
	input wire logic        poweron_reset_off,
	input wire logic        low_volt_reset_off,
	input wire logic [3:0]  low_volt_threshold_sel,
	input wire logic [4:0]  reference_trim_second,
	input wire logic        transient_det2_en,
	input wire logic        transient_det1_en,
	input wire logic [1:0]  transient_det1_sensitivity,
	input wire logic        sw_slow_clock_sel,
	input wire logic        transient_wait_indicator,
	input wire logic        system_clock_use_slow
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire        hs_w  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire        wr_go = hs_w && s_axi_wstrb[0];
	wire [14:0] outs  = {poweron_reset_off, low_volt_reset_off, low_volt_threshold_sel,
		reference_trim_second, transient_det2_en, transient_det1_en, transient_det1_sensitivity};

	a_write_answer: assert property (hs_w |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
		else $error("write response missing after address and data");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before rready");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data missing after address");
	a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_supply_write: assert property (
		wr_go && s_axi_awaddr == ssc_pkg::SUPPLY_MONITOR_CTRL_ADDR |=>
		outs[14:9] == $past(s_axi_wdata[5:0])) else $error("supply control not written");
	a_trim_write: assert property (
		wr_go && s_axi_awaddr == ssc_pkg::BANDGAP_TRIM_SECOND_ADDR |=>
		reference_trim_second == $past(s_axi_wdata[4:0])) else $error("trim not written");
	a_detect_write: assert property (
		wr_go && s_axi_awaddr == ssc_pkg::TRANSIENT_DETECT_CTRL_ADDR |=>
		outs[3:0] == $past(s_axi_wdata[7:4])) else $error("detector control not written");
	a_reset_clear: assert property (disable iff (1'b0) !aresetn |=> outs == 15'h0)
		else $error("controls not cleared by reset");
	a_clock_return: assert property (
		$past(aresetn) && !$past(transient_wait_indicator) |->
		system_clock_use_slow == $past(sw_slow_clock_sel)) else $error("clock not back to software");

	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == ssc_pkg::RESP_SLVERR);
	c_slow: cover property (transient_wait_indicator && system_clock_use_slow);
endmodule : ssc_regs_chk

bind ssc_regs ssc_regs_chk u_chk (.*);

/* File: tb/supply_supervisor_config_regs_test.sv */
`timescale 1ns/1ps
module supply_supervisor_config_regs_test;
	localparam logic [11:0] A0 = ssc_pkg::SUPPLY_MONITOR_CTRL_ADDR;
	localparam logic [11:0] A1 = ssc_pkg::BANDGAP_TRIM_SECOND_ADDR;
	localparam logic [11:0] A2 = ssc_pkg::TRANSIENT_DETECT_CTRL_ADDR;
	typedef struct packed {logic [11:0] a; logic [31:0] d; logic [7:0] r; logic [14:0] o;} ssc_row_s;
	logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0, transient_detected_async = 0;
	logic        sw_slow_clock_sel = 0, gpio_pin_out = 1, gpio_pin_oe = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, data;
	logic [3:0]  s_axi_wstrb = 0, low_volt_threshold_sel;
	logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp, transient_det1_sensitivity;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        poweron_reset_off, low_volt_reset_off, transient_det2_en, transient_det1_en;
	logic        transient_wait_indicator, system_clock_use_slow, shared_pin_out, shared_pin_oe;
	logic [4:0]  reference_trim_second;
	int          err_total = 0, checked = 0;
	wire  [14:0] outs = {poweron_reset_off, low_volt_reset_off, low_volt_threshold_sel,
		reference_trim_second, transient_det2_en, transient_det1_en, transient_det1_sensitivity};
	// Rows build on each other: outputs are cumulative
	ssc_row_s rows [8] = '{'{A0, 32'h3f, 8'h3f, 15'h7e00}, '{A0, 32'hffffff20, 8'h20, 15'h4000},
		'{A0, 32'h15, 8'h15, 15'h2a00}, '{A1, 32'hff, 8'h1f, 15'h2bf0},
		'{A1, 32'h0a, 8'h0a, 15'h2aa0}, '{A2, 32'hff, 8'hfa, 15'h2aaf},
		'{A2, 32'h50, 8'h50, 15'h2aa5}, '{A2, 32'ha0, 8'ha0, 15'h2aaa}};

	ssc_regs dut (.*);
	always #4 aclk = ~aclk;

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask : wr

	task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask : rd

	task rst_chk;
		aresetn <= 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk("reset outputs", 0, outs);
		foreach (rows[k]) if (k % 3 == 0) begin
			rd(rows[k].a, data, resp);
			chk("reset value", 0, data);
		end
	endtask : rst_chk

	task finish_test;
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	initial begin
		repeat (5000) @(posedge aclk);
		err_total++;
		finish_test();
	end

	initial begin
		rst_chk();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, 4'hf, resp);
			chk("write resp", ssc_pkg::RESP_OKAY, resp);
			rd(rows[i].a, data, resp);
			chk("read back", {24'h0, rows[i].r}, data);
			chk("controls", {17'h0, rows[i].o}, outs);
		end
		for (int i = 0; i < 16; i++) begin
			wr(A0, i, 4'hf, resp);
			chk("threshold", i, low_volt_threshold_sel);
		end
		wr(12'h398, 32'hff, 4'hf, resp);
		chk("unmapped bresp", ssc_pkg::RESP_SLVERR, resp);
		rd(12'h398, data, resp);
		chk("unmapped rresp", ssc_pkg::RESP_SLVERR, resp);
		chk("unmapped rdata", 0, data);
		// A write with no byte strobe must leave the trim alone
		wr(A1, 32'h15, 4'h0, resp);
		rd(A1, data, resp);
		chk("masked write", 32'h0a, data);
		wr(A2, 32'h48, 4'hf, resp);
		transient_detected_async <= 1;
		repeat (6) @(posedge aclk);
		chk("indicator", 1, transient_wait_indicator);
		chk("slow forced", 1, system_clock_use_slow);
		chk("pin gpio", 2'b10, {shared_pin_out, shared_pin_oe});
		wr(A2, 32'h4a, 4'hf, resp);
		repeat (3) @(posedge aclk);
		chk("pin wait", 2'b11, {shared_pin_out, shared_pin_oe});
		transient_detected_async <= 0;
		repeat (6) @(posedge aclk);
		chk("pin idle", 2'b01, {shared_pin_out, shared_pin_oe});
		chk("indicator off", 0, transient_wait_indicator);
		chk("clock back", 0, system_clock_use_slow);
		sw_slow_clock_sel <= 1;
		repeat (3) @(posedge aclk);
		chk("sw slow", 1, system_clock_use_slow);
		sw_slow_clock_sel <= 0;
		gpio_pin_out <= 0;
		gpio_pin_oe <= 1;
		wr(A2, 32'h40, 4'hf, resp);
		transient_detected_async <= 1;
		repeat (6) @(posedge aclk);
		chk("no force", 0, system_clock_use_slow);
		chk("pin gpio back", 2'b01, {shared_pin_out, shared_pin_oe});
		transient_detected_async <= 0;
		rst_chk();
		finish_test();
	end
endmodule : supply_supervisor_config_regs_test
